//--- design/sram_pkg.sv
package sram_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W      = 10;
  localparam int DATA_W      = 32;
  localparam int LANES       = 4;
  localparam int LANE_W      = DATA_W / LANES;
  localparam int BURST_W     = 2;
  localparam int BURST_LEN   = 4;

  // ------------------------------------------------------------------
  // Timing counts, in clock cycles
  // ------------------------------------------------------------------
  localparam int RD_PIPE     = 3;
  localparam int TURN_CYCLES = 2;

  typedef logic [ADDR_W-1:0]           addr_t;
  typedef logic [DATA_W-1:0]           data_t;
  typedef logic [LANES-1:0]            lanes_t;
  typedef logic [BURST_W-1:0]          burst_t;
  typedef logic [BURST_LEN*DATA_W-1:0] burst_data_t;
  typedef logic [1:0]                  turn_t;

  localparam burst_t BURST_ZERO = 2'h0;
  localparam burst_t BURST_ONE  = 2'h1;
  localparam burst_t BURST_LAST = 2'h3;
  localparam turn_t  TURN_LOAD  = 2'(TURN_CYCLES);
  localparam turn_t  TURN_ONE   = 2'h1;
  localparam turn_t  TURN_ZERO  = 2'h0;

endpackage

//--- design/sram_bus_if.sv
interface sram_bus_if;
  import sram_pkg::*;

  addr_t  addr;
  data_t  dq_dev;
  logic   dq_dev_oe;
  data_t  dq_ctrl;
  logic   dq_ctrl_oe;
  data_t  dq;
  logic   proc_addr_strobe_n;
  logic   ctrl_addr_strobe_n;
  logic   burst_advance_n;
  logic   global_write_n;
  logic   byte_write_enable_n;
  lanes_t byte_lane_select_n;
  logic   chip_sel_1_n;
  logic   chip_sel_2;
  logic   chip_sel_3_n;
  logic   out_enable_n;

  // Undriven bus reads as all ones, like a weak pull-up
  assign dq = dq_dev_oe ? dq_dev : (dq_ctrl_oe ? dq_ctrl : '1);

  modport dev (
    input  addr, dq, proc_addr_strobe_n, ctrl_addr_strobe_n,
    input  burst_advance_n, global_write_n, byte_write_enable_n,
    input  byte_lane_select_n, chip_sel_1_n, chip_sel_2, chip_sel_3_n,
    input  out_enable_n,
    output dq_dev, dq_dev_oe
  );

  modport ctrl (
    output addr, dq_ctrl, dq_ctrl_oe, proc_addr_strobe_n,
    output ctrl_addr_strobe_n, burst_advance_n, global_write_n,
    output byte_write_enable_n, byte_lane_select_n, chip_sel_1_n,
    output chip_sel_2, chip_sel_3_n, out_enable_n,
    input  dq
  );

endinterface

//--- design/sram_burst_counter.sv
module sram_burst_counter
  import sram_pkg::*;
(
  input  wire logic            i_sys_clk,
  input  wire logic            i_nrst,
  input  wire logic            i_load,
  input  wire sram_pkg::burst_t i_base,
  input  wire logic            i_step,
  input  wire logic            i_linear,
  output sram_pkg::burst_t     o_low
);

  typedef struct packed {
    burst_t base;
    burst_t cnt;
  } cnt_state_t;

  cnt_state_t q;
  cnt_state_t d;

  // ------------------------------------------------------------------
  // Wraparound sequence; o_low is the address used in this cycle
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    if (i_load) begin
      d.base = i_base;
      d.cnt  = BURST_ZERO;
    end else if (i_step) begin
      d.cnt = q.cnt + BURST_ONE;
    end
    if (i_linear) begin
      o_low = d.base + d.cnt;
    end else begin
      o_low = d.base ^ d.cnt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // sram_burst_counter

//--- design/sram_dev_end.sv
// Contract
// - Strap low linear, high interleaved order
// - System holds burst-order strap constant
// - Scan output on falling, inputs rising
// - Register all inputs and data outputs
// - Two-bit counter loads low address bits
// - Advance input alone steps burst address
// - Global write writes every byte lane
// - Processor strobe ignored when select high
// - Read starts on strobe, selects, writes high
// - Read data leaves output register next
// - First cycle after deselect stays floating
// - Later cycles follow output enable only
// - Back-to-back reads; deselect floats outputs
// - Processor write first cycle ignores controls
// - Processor write completes on second rise
// - Byte writes only selected enabled lanes
// - Controller raises output enable before data
// - Any detected write floats data drivers
// - Both strobes: processor strobe wins
// - Controller-strobe write completes same edge
// - Linear order adds one modulo four
// - Interleaved order XORs with step count
module sram_dev_end
  import sram_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_mode_strap,
  input  wire logic i_tck,
  input  wire logic i_tdi,
  input  wire logic i_tms,
  output logic      o_tdo,
  sram_bus_if.dev   bus
);

  localparam int HI_W = ADDR_W - BURST_W;

  typedef logic [HI_W-1:0] addr_hi_t;

  typedef struct packed {
    addr_t  addr;
    data_t  dq;
    logic   ps_n;
    logic   cs_n;
    logic   adv_n;
    logic   gw_n;
    logic   bwe_n;
    lanes_t bls_n;
    logic   cs1_n;
    logic   cs2;
    logic   cs3_n;
    logic   oe_n;
  } pins_t;

  typedef struct packed {
    pins_t    in;
    addr_hi_t addr_hi;
    logic     active;
    logic     linear;
    data_t    dout;
    logic     dq_oe;
    logic     tck;
    logic     bypass;
    logic     tdo;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;

  data_t mem [2**ADDR_W];

  logic   proc_sel;
  logic   ctrl_sel;
  logic   strobe;
  logic   selected;
  logic   load;
  logic   step;
  lanes_t wr_lanes;
  logic   wr;
  burst_t low;
  addr_t  acc_addr;

  // Global write overrides lanes; otherwise enable gates each select
  function automatic lanes_t write_lanes(input logic   gw_n,
                                         input logic   bwe_n,
                                         input lanes_t bls_n);
    if (!gw_n) begin
      write_lanes = '1;
    end else if (!bwe_n) begin
      write_lanes = ~bls_n;
    end else begin
      write_lanes = '0;
    end
  endfunction

  // ------------------------------------------------------------------
  // Access decode, from the input register and the active flag
  // ------------------------------------------------------------------
  always_comb begin
    proc_sel = !q.in.ps_n && !q.in.cs1_n;
    ctrl_sel = !q.in.cs_n && !proc_sel;
    strobe   = proc_sel || ctrl_sel;
    selected = !q.in.cs1_n && q.in.cs2 && !q.in.cs3_n;
    load     = strobe && selected;
    step     = !strobe && q.active && !q.in.adv_n;
    if (proc_sel) begin
      wr_lanes = '0;
    end else if (ctrl_sel) begin
      wr_lanes = selected
               ? write_lanes(q.in.gw_n, q.in.bwe_n, q.in.bls_n)
               : '0;
    end else if (q.active) begin
      wr_lanes = write_lanes(q.in.gw_n, q.in.bwe_n, q.in.bls_n);
    end else begin
      wr_lanes = '0;
    end
    wr = |wr_lanes;
  end

  sram_burst_counter u_counter (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_load    (load),
    .i_base    (q.in.addr[BURST_W-1:0]),
    .i_step    (step),
    .i_linear  (q.linear),
    .o_low     (low)
  );

  assign acc_addr = load ? q.in.addr : {q.addr_hi, low};

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.in.addr  = bus.addr;
    d.in.dq    = bus.dq;
    d.in.ps_n  = bus.proc_addr_strobe_n;
    d.in.cs_n  = bus.ctrl_addr_strobe_n;
    d.in.adv_n = bus.burst_advance_n;
    d.in.gw_n  = bus.global_write_n;
    d.in.bwe_n = bus.byte_write_enable_n;
    d.in.bls_n = bus.byte_lane_select_n;
    d.in.cs1_n = bus.chip_sel_1_n;
    d.in.cs2   = bus.chip_sel_2;
    d.in.cs3_n = bus.chip_sel_3_n;
    d.in.oe_n  = bus.out_enable_n;
    // Strap sampled every cycle; a moving strap upsets open bursts
    d.linear   = !i_mode_strap;

    if (strobe) begin
      d.active = load;
    end
    if (load) begin
      d.addr_hi = q.in.addr[ADDR_W-1:BURST_W];
    end

    // Array word goes through the output register one edge later
    d.dout = mem[acc_addr];

    if (strobe && !selected) begin
      d.dq_oe = 1'b0;
    end else if (wr) begin
      d.dq_oe = 1'b0;
    end else if (load) begin
      d.dq_oe = !q.in.oe_n;
    end else if (q.active) begin
      d.dq_oe = !q.in.oe_n;
    end else begin
      // Emerging from deselect: nothing valid to drive yet
      d.dq_oe = 1'b0;
    end

    // Minimal scan path: one bypass stage between TDI and TDO
    d.tck = i_tck;
    if (i_tck && !q.tck) begin
      d.bypass = i_tdi && !i_tms;
    end
    if (!i_tck && q.tck) begin
      d.tdo = q.bypass;
    end
  end

  // ------------------------------------------------------------------
  // Registers and array
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge i_sys_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_lanes[l]) begin
        mem[acc_addr][l*LANE_W +: LANE_W] <= q.in.dq[l*LANE_W +: LANE_W];
      end
    end
  end

  assign bus.dq_dev    = q.dout;
  assign bus.dq_dev_oe = q.dq_oe;
  assign o_tdo         = q.tdo;

endmodule // sram_dev_end

//--- design/sram_ctrl_end.sv
module sram_ctrl_end
  import sram_pkg::*;
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_req_valid,
  input  wire logic                   i_req_write,
  input  wire logic                   i_req_burst,
  input  wire logic                   i_req_proc,
  input  wire sram_pkg::addr_t        i_req_addr,
  input  wire sram_pkg::lanes_t       i_req_lanes,
  input  wire sram_pkg::burst_data_t  i_req_wdata,
  output logic                        o_req_ready,
  output sram_pkg::data_t             o_rd_data,
  output logic                        o_rd_valid,
  sram_bus_if.ctrl                    bus
);

  typedef enum {C_IDLE, C_FIRST, C_BURST} ctrl_fsm_t;

  typedef struct packed {
    ctrl_fsm_t            state;
    addr_t                addr;
    data_t                dq;
    logic                 dq_oe;
    logic                 ps_n;
    logic                 cs_n;
    logic                 adv_n;
    logic                 gw_n;
    logic                 bwe_n;
    lanes_t               bls_n;
    logic                 cs1_n;
    logic                 cs2;
    logic                 cs3_n;
    logic                 oe_n;
    logic                 write;
    lanes_t               lanes;
    burst_t               left;
    burst_data_t          wbuf;
    logic [RD_PIPE-1:0]   rd_pipe;
    turn_t                turn;
    data_t                rdata;
    logic                 rvalid;
    logic                 ready;
  } ctrl_state_t;

  ctrl_state_t q;
  ctrl_state_t d;

  // Put one write beat on the pins and advance the data buffer
  function automatic ctrl_state_t put_beat(input ctrl_state_t s);
    put_beat = s;
    if (&s.lanes) begin
      put_beat.gw_n = 1'b0;
    end else begin
      put_beat.bwe_n = 1'b0;
      put_beat.bls_n = ~s.lanes;
    end
    put_beat.dq    = s.wbuf[DATA_W-1:0];
    put_beat.dq_oe = 1'b1;
    put_beat.oe_n  = 1'b1;
    put_beat.wbuf  = s.wbuf >> DATA_W;
  endfunction

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.ps_n    = 1'b1;
    d.cs_n    = 1'b1;
    d.adv_n   = 1'b1;
    d.gw_n    = 1'b1;
    d.bwe_n   = 1'b1;
    d.bls_n   = '1;
    d.dq_oe   = 1'b0;
    d.cs1_n   = 1'b0;
    d.cs2     = 1'b1;
    d.cs3_n   = 1'b0;
    d.rd_pipe = {q.rd_pipe[RD_PIPE-2:0], 1'b0};
    d.rvalid  = q.rd_pipe[RD_PIPE-1];
    d.rdata   = bus.dq;
    d.turn    = (q.turn == TURN_ZERO) ? TURN_ZERO : q.turn - TURN_ONE;
    // Hold output enable low until read data has drained
    d.oe_n    = (q.turn == TURN_ZERO);

    unique case (q.state)
      C_IDLE: begin
        if (i_req_valid && q.ready) begin
          d.addr  = i_req_addr;
          d.write = i_req_write;
          d.lanes = i_req_lanes;
          d.wbuf  = i_req_wdata;
          d.left  = i_req_burst ? BURST_LAST : BURST_ZERO;
          if (i_req_proc) begin
            d.ps_n = 1'b0;
          end else begin
            d.cs_n = 1'b0;
          end
          if (!i_req_write) begin
            d.oe_n       = 1'b0;
            d.rd_pipe[0] = 1'b1;
            d.turn       = TURN_LOAD;
            d.state      = i_req_burst ? C_BURST : C_IDLE;
          end else if (i_req_proc) begin
            d.oe_n  = 1'b1;
            d.state = C_FIRST;
          end else begin
            d       = put_beat(d);
            d.state = i_req_burst ? C_BURST : C_IDLE;
          end
        end
      end
      C_FIRST: begin
        // Second rise of a processor-strobe write: first address
        d       = put_beat(d);
        d.state = (q.left == BURST_ZERO) ? C_IDLE : C_BURST;
      end
      C_BURST: begin
        d.adv_n = 1'b0;
        d.left  = q.left - BURST_ONE;
        if (q.write) begin
          d = put_beat(d);
        end else begin
          d.oe_n       = 1'b0;
          d.rd_pipe[0] = 1'b1;
          d.turn       = TURN_LOAD;
        end
        d.state = (q.left == BURST_ONE) ? C_IDLE : C_BURST;
      end
    endcase

    // Output enable must already stand high before a write is taken
    d.ready = (d.state == C_IDLE) && (d.turn == TURN_ZERO) && q.oe_n
              && d.oe_n;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Pins and user side, all from flops
  // ------------------------------------------------------------------
  assign bus.addr                = q.addr;
  assign bus.dq_ctrl             = q.dq;
  assign bus.dq_ctrl_oe          = q.dq_oe;
  assign bus.proc_addr_strobe_n  = q.ps_n;
  assign bus.ctrl_addr_strobe_n  = q.cs_n;
  assign bus.burst_advance_n     = q.adv_n;
  assign bus.global_write_n      = q.gw_n;
  assign bus.byte_write_enable_n = q.bwe_n;
  assign bus.byte_lane_select_n  = q.bls_n;
  assign bus.chip_sel_1_n        = q.cs1_n;
  assign bus.chip_sel_2          = q.cs2;
  assign bus.chip_sel_3_n        = q.cs3_n;
  assign bus.out_enable_n        = q.oe_n;
  assign o_req_ready             = q.ready;
  assign o_rd_data               = q.rdata;
  assign o_rd_valid              = q.rvalid;

endmodule // sram_ctrl_end

//--- verif/sram_bus_checker.sv
module sram_bus_checker (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic dq_dev_oe,
  input wire logic dq_ctrl_oe,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic chip_sel_1_n,
  input wire logic chip_sel_2,
  input wire logic chip_sel_3_n,
  input wire logic out_enable_n
);
  logic sel;
  logic rd;
  assign sel = !chip_sel_1_n && chip_sel_2 && !chip_sel_3_n;
  assign rd  = global_write_n && byte_write_enable_n && !out_enable_n;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // ------------------------------------------------------------------
  // Pin-level relations
  // ------------------------------------------------------------------
  property p_ctrl_write_floats;
    !ctrl_addr_strobe_n && proc_addr_strobe_n && sel && !global_write_n
      |-> ##2 !dq_dev_oe;
  endproperty
  a_ctrl_write_floats: assert property (p_ctrl_write_floats)
    else $error("device drove bus for a write");

  property p_oe_floats;
    out_enable_n ##1 out_enable_n |=> !dq_dev_oe;
  endproperty
  a_oe_floats: assert property (p_oe_floats)
    else $error("device drove bus with output enable high");

  property p_read_drives;
    (!proc_addr_strobe_n || !ctrl_addr_strobe_n) && sel && rd
      ##1 !out_enable_n |=> dq_dev_oe;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("read data not driven");

  property p_burst_drives;
    !burst_advance_n && proc_addr_strobe_n && ctrl_addr_strobe_n && rd
      ##1 !out_enable_n |=> dq_dev_oe;
  endproperty
  a_burst_drives: assert property (p_burst_drives)
    else $error("burst beat not driven");

  property p_proc_write_floats;
    !proc_addr_strobe_n && sel ##1 proc_addr_strobe_n && !global_write_n
      |-> ##2 !dq_dev_oe;
  endproperty
  a_proc_write_floats: assert property (p_proc_write_floats)
    else $error("device drove bus during two-clock write");

  property p_no_contention;
    !(dq_dev_oe && dq_ctrl_oe);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data lines");

  property p_data_with_oe_high;
    proc_addr_strobe_n && (!global_write_n || !byte_write_enable_n)
      |-> dq_ctrl_oe && out_enable_n;
  endproperty
  a_data_with_oe_high: assert property (p_data_with_oe_high)
    else $error("write controls without data or with oe low");

  property p_oe_before_data;
    $rose(dq_ctrl_oe) |-> $past(out_enable_n);
  endproperty
  a_oe_before_data: assert property (p_oe_before_data)
    else $error("controller drove data before raising oe");

  c_read: cover property (!ctrl_addr_strobe_n && rd ##2 dq_dev_oe);
  c_burst: cover property (!burst_advance_n [*3]);
  c_proc_write: cover property (!proc_addr_strobe_n ##1 !global_write_n);
endmodule // sram_bus_checker

//--- verif/pipelined_sync_sram_access_tb.sv
module pipelined_sync_sram_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_pkg::*;

  logic        i_sys_clk, i_nrst, mode_strap, tck, tdi, tms, tdo;
  logic        req_valid, req_write, req_burst, req_proc;
  logic        req_ready, rd_valid;
  addr_t       req_addr;
  lanes_t      req_lanes;
  burst_data_t req_wdata;
  data_t       rd_data;
  data_t       mem [0:1023];
  data_t       exp_q [$];
  logic [31:0] seed = 32'h6ef6;
  logic [31:0] r;
  int          mismatches, tests_run, cycles;

  sram_bus_if bus_if ();
  sram_dev_end sram_dev_end_inst (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_mode_strap(mode_strap),
    .i_tck(tck), .i_tdi(tdi), .i_tms(tms), .o_tdo(tdo), .bus(bus_if.dev));
  sram_ctrl_end sram_ctrl_end_inst (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_req_valid(req_valid),
    .i_req_write(req_write), .i_req_burst(req_burst),
    .i_req_proc(req_proc), .i_req_addr(req_addr),
    .i_req_lanes(req_lanes), .i_req_wdata(req_wdata),
    .o_req_ready(req_ready), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .bus(bus_if.ctrl));
  sram_bus_checker sram_bus_checker_inst (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .dq_dev_oe(bus_if.dq_dev_oe), .dq_ctrl_oe(bus_if.dq_ctrl_oe),
    .proc_addr_strobe_n(bus_if.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(bus_if.ctrl_addr_strobe_n),
    .burst_advance_n(bus_if.burst_advance_n),
    .global_write_n(bus_if.global_write_n),
    .byte_write_enable_n(bus_if.byte_write_enable_n),
    .chip_sel_1_n(bus_if.chip_sel_1_n), .chip_sel_2(bus_if.chip_sel_2),
    .chip_sel_3_n(bus_if.chip_sel_3_n),
    .out_enable_n(bus_if.out_enable_n));

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic addr_t beat_addr(addr_t a, int k, logic m);
    burst_t s;
    s = m ? (a[1:0] ^ burst_t'(k)) : (a[1:0] + burst_t'(k));
    return {a[ADDR_W-1:2], s};
  endfunction

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Model is updated when the request is taken, so reads see prior writes
  // Beat k of a burst carries d ^ k
  task automatic req(input logic w, b, p, input addr_t a,
                     input lanes_t l, input data_t d);
    int    n;
    addr_t ba;
    data_t bd;
    n = 0;
    @(negedge i_sys_clk);
    req_valid = 1'b1;
    req_write = w;
    req_burst = b;
    req_proc  = p;
    req_addr  = a;
    req_lanes = l;
    req_wdata = {d ^ 32'h3, d ^ 32'h2, d ^ 32'h1, d};
    while (req_ready !== 1'b1 && n < 60) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk(req_ready === 1'b1, "request not accepted");
    @(negedge i_sys_clk);
    req_valid = 1'b0;
    for (int k = 0; k <= (b ? 3 : 0); k++) begin
      ba = beat_addr(a, k, mode_strap);
      bd = d ^ data_t'(k);
      for (int i = 0; i < LANES && w; i++) begin
        if (l[i]) mem[ba][LANE_W*i +: LANE_W] = bd[LANE_W*i +: LANE_W];
      end
      if (!w) exp_q.push_back(mem[ba]);
    end
  endtask

  // Scan clock is slow data here, three system cycles high, seven low between bits
  task automatic scan_bit(input logic d, input logic s);
    @(negedge i_sys_clk);
    tdi = d;
    tms = s;
    repeat (3) @(negedge i_sys_clk);
    tck = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    tck = 1'b0;
    repeat (3) @(negedge i_sys_clk);
    chk(tdo === (d & ~s), "scan bypass bit");
  endtask

  always @(negedge i_sys_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected read beat");
      else chk(rd_data === exp_q.pop_front(), "read data");
    end
  end

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    {i_nrst, mode_strap, tck, tdi, tms} = 5'h0;
    {req_valid, req_write, req_burst, req_proc} = 4'h0;
    req_addr  = '0;
    req_lanes = '0;
    req_wdata = '0;
    repeat (20) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    for (int b = 0; b < 8; b++) begin
      r = rnd();
      scan_bit(r[0], b[2]);
    end
    $display("test scan done");
    for (int m = 0; m < 2; m++) begin
      mode_strap = m[0];
      for (int i = 0; i < 16; i++) begin
        req(1'b1, 1'b0, i[0], addr_t'(64*m + i), 4'hf, rnd());
      end
      for (int i = 0; i < 12; i++) begin
        r = rnd();
        req(1'b1, r[9], r[4], addr_t'(64*m) + addr_t'(r[3:0]), r[8:5],
            rnd());
      end
      for (int i = 0; i < 12; i++) begin
        r = rnd();
        if (i < 4) r[5:0] = {1'b1, i[0], i[1:0], i[1:0]};
        req(1'b0, r[5], r[4], addr_t'(64*m) + addr_t'(r[3:0]), 4'hf,
            32'h0);
      end
      for (int n = 0; n < 60 && exp_q.size() != 0; n++) begin
        @(negedge i_sys_clk);
      end
      chk(exp_q.size() == 0, "read beats missing");
      $display("test burst order %0d done", m);
    end
    report_and_stop();
  end
endmodule // pipelined_sync_sram_access_tb
